// ==== common/ccw_pkg.sv ====
// ccw_pkg: constants, enums and carrier structs for the clear / invert / watchdog-restart execution block
// assumes a 16-bit program word and a 12-bit data address (16 banks of 256 bytes)
package ccw_pkg;

    // -------------------------------------------------------------------
    // opcode patterns
    // -------------------------------------------------------------------
    localparam logic [6:0] CCW_CLR_OPC = 7'h35;              // 0110 101
    localparam logic [5:0] CCW_INV_OPC = 6'h07;              // 0001 11
    localparam logic [15:0] CCW_WDT_OPC = 16'h0004;          // 0000 0000 0000 0100
    localparam int CCW_CLR_MSB = 15;
    localparam int CCW_CLR_LSB = 9;
    localparam int CCW_INV_LSB = 10;
    localparam int CCW_DEST_BIT = 9;
    localparam int CCW_BANK_BIT = 8;

    // -------------------------------------------------------------------
    // addressing
    // -------------------------------------------------------------------
    localparam int CCW_ADDR_W = 12;
    localparam int CCW_BANK_W = 4;
    localparam logic [7:0] CCW_IDX_LIMIT = 8'h5f;           // offsets 0..95 use indexed mode
    localparam logic [7:0] CCW_ACC_SPLIT = 8'h80;           // lower access half maps to bank 0
    localparam logic [3:0] CCW_ACC_LO_BANK = 4'h0;
    localparam logic [3:0] CCW_ACC_HI_BANK = 4'hf;

    // -------------------------------------------------------------------
    // results and reset values
    // -------------------------------------------------------------------
    localparam logic [7:0] CCW_CLEAR_VAL = 8'h00;
    localparam logic [7:0] CCW_BYTE_RST = 8'h00;
    localparam logic [11:0] CCW_ADDR_RST = 12'h000;
    localparam int CCW_SIGN_BIT = 7;

    typedef enum logic [1:0] {
        CCW_Q1 = 2'b00,
        CCW_Q2 = 2'b01,
        CCW_Q3 = 2'b10,
        CCW_Q4 = 2'b11
    } ccw_phase_e;

    typedef enum logic [1:0] {
        CCW_OP_NONE = 2'b00,
        CCW_OP_CLR = 2'b01,
        CCW_OP_WDT = 2'b10,
        CCW_OP_INV = 2'b11
    } ccw_op_e;

    // data memory request
    typedef struct packed {
        logic rd;
        logic we;
        logic [11:0] addr;
        logic [7:0] wdata;
    } ccw_mem_s;

    // status flag updates
    typedef struct packed {
        logic z_we;
        logic z_val;
        logic n_we;
        logic n_val;
        logic to_set;
        logic pd_set;
    } ccw_flag_s;

    // whole block state
    typedef struct packed {
        ccw_phase_e phase;
        ccw_op_e op;
        logic dest_w;
        logic bank_sel;
        logic idx_mode;
        logic [7:0] offset;
        ccw_mem_s mem;
        ccw_flag_s flag;
        logic w_we;
        logic [7:0] w_data;
        logic wdt_clr;
    } ccw_state_s;

endpackage

// ==== logic/ccw_exec.sv ====
// ccw_exec: executes the register clear, register invert and watchdog restart instructions
// assumes fetch, data memory, status and watchdog logic all run on sys_clk; memory read data
// is valid in the cycle after a read request
//
// Functional notes
// - the register clear instruction writes 00h to its register and sets the result-clear flag.
// - bank bit 0 addresses the access bank, bank bit 1 the general purpose bank named by the bank pointer.
// - with the extended set on, bank bit 0 and offset up to 5Fh, the operand is indexed from a base.
// - the watchdog restart instruction clears the watchdog counter and its postscaler.
// - the watchdog restart instruction sets the timeout and sleep status bits and no other flag.
// - the register invert instruction complements the operand and updates sign and result-clear flags.
// - for invert, destination bit 1 writes the working register, destination bit 0 the operand register.
`timescale 1ns/10ps
`default_nettype none

module ccw_exec
    import ccw_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic ext_set_en,
    input wire logic [3:0] bank_pointer_register,
    input wire logic [11:0] index_base,
    input wire logic [7:0] mem_rdata,
    output logic [1:0] phase,
    output ccw_mem_s mem_req,
    output ccw_flag_s flag_upd,
    output logic w_we,
    output logic [7:0] w_data,
    output logic wdt_clr
);

    ccw_state_s st_reg;
    ccw_state_s st_next;
    logic is_clr;
    logic is_inv;
    logic is_wdt;
    logic [7:0] res;

    // -------------------------------------------------------------------
    // decode
    // -------------------------------------------------------------------
    assign is_clr = instr_word[CCW_CLR_MSB:CCW_CLR_LSB] == CCW_CLR_OPC;
    assign is_inv = instr_word[CCW_CLR_MSB:CCW_INV_LSB] == CCW_INV_OPC;
    assign is_wdt = instr_word == CCW_WDT_OPC;

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.mem.rd = 1'b0;
        st_next.mem.we = 1'b0;
        st_next.flag = '0;
        st_next.w_we = 1'b0;
        st_next.wdt_clr = 1'b0;
        res = CCW_BYTE_RST;
        unique case (st_reg.phase)
            CCW_Q1: begin
                st_next.phase = CCW_Q2;
                st_next.op = CCW_OP_NONE;
                if (instr_valid) begin
                    st_next.op = is_wdt ? CCW_OP_WDT : is_clr ? CCW_OP_CLR : is_inv ? CCW_OP_INV : CCW_OP_NONE;
                    st_next.dest_w = is_inv & instr_word[CCW_DEST_BIT];
                    st_next.bank_sel = instr_word[CCW_BANK_BIT];
                    st_next.offset = instr_word[7:0];
                    st_next.idx_mode = ext_set_en && !instr_word[CCW_BANK_BIT] && instr_word[7:0] <= CCW_IDX_LIMIT;
                    if ((is_clr || is_inv) && !is_wdt) begin
                        st_next.mem.rd = 1'b1;
                        if (st_next.idx_mode) begin
                            st_next.mem.addr = index_base + {4'h0, instr_word[7:0]};
                        end else if (instr_word[CCW_BANK_BIT]) begin
                            st_next.mem.addr = {bank_pointer_register, instr_word[7:0]};
                        end else if (instr_word[7:0] < CCW_ACC_SPLIT) begin
                            st_next.mem.addr = {CCW_ACC_LO_BANK, instr_word[7:0]};
                        end else begin
                            st_next.mem.addr = {CCW_ACC_HI_BANK, instr_word[7:0]};
                        end
                    end
                end
            end
            // read phase; the watchdog restart acts in the process phase
            CCW_Q2: begin
                st_next.phase = CCW_Q3;
                if (st_reg.op == CCW_OP_WDT) begin
                    st_next.wdt_clr = 1'b1;
                    st_next.flag.to_set = 1'b1;
                    st_next.flag.pd_set = 1'b1;
                end
            end
            // process phase, result lands in the write phase
            CCW_Q3: begin
                st_next.phase = CCW_Q4;
                if (st_reg.op == CCW_OP_CLR) begin
                    res = CCW_CLEAR_VAL;
                    st_next.mem.we = 1'b1;
                    st_next.mem.wdata = res;
                    st_next.flag.z_we = 1'b1;
                    st_next.flag.z_val = 1'b1;
                end else if (st_reg.op == CCW_OP_INV) begin
                    res = ~mem_rdata;
                    st_next.flag.z_we = 1'b1;
                    st_next.flag.z_val = res == CCW_BYTE_RST;
                    st_next.flag.n_we = 1'b1;
                    st_next.flag.n_val = res[CCW_SIGN_BIT];
                    if (st_reg.dest_w) begin
                        st_next.w_we = 1'b1;
                        st_next.w_data = res;
                    end else begin
                        st_next.mem.we = 1'b1;
                        st_next.mem.wdata = res;
                    end
                end
            end
            CCW_Q4: begin
                st_next.phase = CCW_Q1;
            end
        endcase
    end

    // -------------------------------------------------------------------
    // state register
    // -------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st_reg <= '{phase: CCW_Q1, op: CCW_OP_NONE, dest_w: 1'b0, bank_sel: 1'b0, idx_mode: 1'b0,
                        offset: CCW_BYTE_RST, mem: '{rd: 1'b0, we: 1'b0, addr: CCW_ADDR_RST, wdata: CCW_BYTE_RST},
                        flag: '0, w_we: 1'b0, w_data: CCW_BYTE_RST, wdt_clr: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign phase = st_reg.phase;
    assign mem_req = st_reg.mem;
    assign flag_upd = st_reg.flag;
    assign w_we = st_reg.w_we;
    assign w_data = st_reg.w_data;
    assign wdt_clr = st_reg.wdt_clr;

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    clr_write_zero_a: assert property (
        (mem_req.we && st_reg.op == CCW_OP_CLR) |-> (mem_req.wdata == 8'h00 && flag_upd.z_we && flag_upd.z_val))
        else $error("clear did not write zero with zero flag");

    bank_pointer_a: assert property (
        (mem_req.rd && st_reg.bank_sel) |-> mem_req.addr == {$past(bank_pointer_register), st_reg.offset})
        else $error("banked address not from bank pointer");

    indexed_addr_a: assert property (
        (mem_req.rd && st_reg.idx_mode) |-> (!st_reg.bank_sel && st_reg.offset <= 8'h5f
            && mem_req.addr == $past(index_base) + {4'h0, st_reg.offset}))
        else $error("indexed operand address wrong");

    wdt_restart_a: assert property (
        (st_reg.phase == CCW_Q2 && st_reg.op == CCW_OP_WDT) |=> (wdt_clr && phase == 2'b10) ##1 !wdt_clr)
        else $error("watchdog restart not one pulse in process phase");

    wdt_flags_only_a: assert property (
        wdt_clr |-> (flag_upd.to_set && flag_upd.pd_set && !flag_upd.z_we && !flag_upd.n_we && !mem_req.we))
        else $error("watchdog restart flag update wrong");

    invert_result_a: assert property (
        (mem_req.rd ##2 (st_reg.op == CCW_OP_INV)) |-> (((w_we ? w_data : mem_req.wdata) == ~$past(mem_rdata))
            && flag_upd.n_val == ~$past(mem_rdata[7]) && flag_upd.z_val == ($past(mem_rdata) == 8'hff)))
        else $error("invert result or flags wrong");

    invert_dest_a: assert property (
        (st_reg.op == CCW_OP_INV && phase == 2'b11) |-> (w_we == st_reg.dest_w && mem_req.we == !st_reg.dest_w))
        else $error("invert destination wrong");

    one_cycle_a: assert property (
        (mem_req.rd && st_reg.op != CCW_OP_NONE) |-> ##2 ((mem_req.we || w_we) && phase == 2'b11) ##1 phase == 2'b00)
        else $error("operand write not in write phase");

    rd_phase_a: assert property (
        mem_req.rd |-> st_reg.phase == CCW_Q2)
        else $error("operand read outside read phase");

    write_phase_a: assert property (
        (mem_req.we || w_we || flag_upd.z_we || flag_upd.n_we) |-> st_reg.phase == CCW_Q4)
        else $error("result write outside write phase");

    idle_quiet_a: assert property (
        (st_reg.op == CCW_OP_NONE) |-> !(mem_req.rd || mem_req.we || w_we || wdt_clr || flag_upd.z_we))
        else $error("strobe without a decoded instruction");

    operand_read_a: assert property (
        (st_reg.phase == CCW_Q2 && (st_reg.op == CCW_OP_CLR || st_reg.op == CCW_OP_INV)) |-> mem_req.rd)
        else $error("operand not read in read phase");

    access_bank_a: assert property (
        (mem_req.rd && !st_reg.bank_sel && !st_reg.idx_mode) |-> mem_req.addr
            == {(st_reg.offset < CCW_ACC_SPLIT) ? CCW_ACC_LO_BANK : CCW_ACC_HI_BANK, st_reg.offset})
        else $error("access bank address wrong");

    index_select_a: assert property (
        mem_req.rd |-> st_reg.idx_mode
            == ($past(ext_set_en) && !st_reg.bank_sel && st_reg.offset <= CCW_IDX_LIMIT))
        else $error("indexed mode chosen wrongly");

    wdt_no_access_a: assert property (
        (st_reg.op == CCW_OP_WDT) |-> !(mem_req.rd || mem_req.we || w_we))
        else $error("watchdog restart touched an operand");

    status_pulse_a: assert property (
        (flag_upd.to_set || flag_upd.pd_set) |-> (wdt_clr && flag_upd.to_set && flag_upd.pd_set))
        else $error("timeout or sleep bit set without restart");

    clr_no_sign_a: assert property (
        (st_reg.op == CCW_OP_CLR) |-> !(flag_upd.n_we || w_we))
        else $error("clear touched sign flag or working register");

endmodule

`default_nettype wire

// ==== verif/ccw_mem_model.sv ====
// ccw_mem_model: behavioural data memory facing the execution block
// assumes read data is wanted in the cycle after a read strobe
`timescale 1ns/10ps
`default_nettype none

module ccw_mem_model
    import ccw_pkg::*;
(
    input wire logic sys_clk,
    input wire ccw_mem_s mem_req,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:4095];
    logic rd_seen;

    initial begin
        rd_seen = 1'b0;
        mem_rdata = 8'h00;
    end

    always @(posedge sys_clk) begin
        rd_seen <= mem_req.rd;
        if (mem_req.we) begin
            mem[mem_req.addr] <= mem_req.wdata;
        end
    end

    // outside the read slot the bus shows a changing pattern
    always @(negedge sys_clk) begin
        mem_rdata <= rd_seen ? mem[mem_req.addr] : ~mem_rdata;
    end
endmodule

`default_nettype wire

// ==== verif/ccw_exec_tb.sv ====
// ccw_exec_tb: self-checking bench for the clear / invert / watchdog-restart block
// assumes the behavioural data memory model sits on the memory port
`timescale 1ns/10ps
`default_nettype none

module ccw_exec_tb
    import ccw_pkg::*;
;
    // ---------------------------------------------------------------
    // signals and instances
    // ---------------------------------------------------------------
    logic sys_clk, rstn, instr_valid, ext_set_en, w_we, wdt_clr;
    logic [15:0] instr_word;
    logic [3:0] bank_pointer_register;
    logic [11:0] index_base;
    logic [7:0] mem_rdata, w_data, swd;
    logic [1:0] phase;
    ccw_mem_s mem_req;
    ccw_flag_s flag_upd;
    int err_count, total_checks;
    ccw_mem_s sm [1:3];
    ccw_flag_s sf [1:3];
    logic sw [1:3];
    logic sx [1:3];

    ccw_exec ccw_exec_i (.sys_clk(sys_clk), .rstn(rstn), .instr_valid(instr_valid), .instr_word(instr_word),
        .ext_set_en(ext_set_en), .bank_pointer_register(bank_pointer_register), .index_base(index_base),
        .mem_rdata(mem_rdata), .phase(phase), .mem_req(mem_req), .flag_upd(flag_upd), .w_we(w_we),
        .w_data(w_data), .wdt_clr(wdt_clr));
    ccw_mem_model ccw_mem_model_i (.sys_clk(sys_clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wait_phase(input logic [1:0] p);
        int n;
        n = 0;
        while (phase !== p && n < 8) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 8) begin
            err_count++;
            print_verdict();
        end
    endtask

    // present one word in Q1 and capture the three following cycles
    task automatic exec(input logic [15:0] word);
        wait_phase(2'd0);
        instr_valid = 1'b1;
        instr_word = word;
        for (int i = 1; i <= 3; i++) begin
            @(negedge sys_clk);
            instr_valid = 1'b0;
            sm[i] = mem_req;
            sf[i] = flag_upd;
            sw[i] = w_we;
            sx[i] = wdt_clr;
        end
        swd = w_data;
    endtask

    function automatic logic [3:0] fl(input ccw_flag_s f);
        return {f.z_we, f.n_we, f.to_set, f.pd_set};
    endfunction

    task automatic verify(input logic rd, input logic [11:0] addr, input logic we, input logic [7:0] wd,
        input logic wwe, input logic [7:0] wv, input logic [3:0] e3, input logic [3:0] e4, input logic [1:0] zn);
        chk("rd_q2", 12'(rd), 12'(sm[1].rd));
        if (rd) chk("addr", addr, sm[1].addr);
        chk("we_q4", 12'(we), 12'(sm[3].we));
        if (we) chk("wdata", 12'(wd), 12'(sm[3].wdata));
        chk("w_we_q4", 12'(wwe), 12'(sw[3]));
        if (wwe) chk("w_data", 12'(wv), 12'(swd));
        chk("flags_q3", 12'(e3), 12'(fl(sf[2])));
        chk("flags_q4", 12'(e4), 12'(fl(sf[3])));
        if (e4[3]) chk("z_val", 12'(zn[1]), 12'(sf[3].z_val));
        if (e4[2]) chk("n_val", 12'(zn[0]), 12'(sf[3].n_val));
        chk("wdt_clr_q3", 12'(e3[1]), 12'(sx[2]));
        chk("stray_strobe", 12'h000, 12'({sm[1].we, sm[2].we, sw[1], sw[2], sx[1], sx[3], fl(sf[1])}));
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    // clear via pointer
    task automatic t_clear;
        bank_pointer_register = 4'h3;
        ccw_mem_model_i.mem[12'h35a] = 8'h5a;
        exec({7'h35, 1'b1, 8'h5a});
        verify(1'b1, 12'h35a, 1'b1, 8'h00, 1'b0, 8'h00, 4'h0, 4'h8, 2'b10);
        @(negedge sys_clk);
        chk("mem_35a", 12'h000, 12'(ccw_mem_model_i.mem[12'h35a]));
    endtask

    task automatic t_inv_mem;
        ccw_mem_model_i.mem[12'hf90] = 8'h13;
        exec({6'h07, 1'b0, 1'b0, 8'h90});
        verify(1'b1, 12'hf90, 1'b1, 8'hec, 1'b0, 8'h00, 4'h0, 4'hc, 2'b01);
        @(negedge sys_clk);
        chk("mem_f90", 12'h0ec, 12'(ccw_mem_model_i.mem[12'hf90]));
    endtask

    task automatic t_inv_w;
        ccw_mem_model_i.mem[12'h010] = 8'hff;
        exec({6'h07, 1'b1, 1'b0, 8'h10});
        verify(1'b1, 12'h010, 1'b0, 8'h00, 1'b1, 8'h00, 4'h0, 4'hc, 2'b10);
        ccw_mem_model_i.mem[12'h011] = 8'h3c;
        exec({6'h07, 1'b1, 1'b0, 8'h11});
        verify(1'b1, 12'h011, 1'b0, 8'h00, 1'b1, 8'hc3, 4'h0, 4'hc, 2'b01);
        @(negedge sys_clk);
        chk("mem_011", 12'h03c, 12'(ccw_mem_model_i.mem[12'h011]));
    endtask

    task automatic t_wdt;
        exec(16'h0004);
        verify(1'b0, 12'h000, 1'b0, 8'h00, 1'b0, 8'h00, 4'h3, 4'h0, 2'b00);
        exec(16'h0004);
        verify(1'b0, 12'h000, 1'b0, 8'h00, 1'b0, 8'h00, 4'h3, 4'h0, 2'b00);
    endtask

    task automatic t_indexed;
        ext_set_en = 1'b1;
        index_base = 12'h200;
        exec({7'h35, 1'b0, 8'h5f});
        verify(1'b1, 12'h25f, 1'b1, 8'h00, 1'b0, 8'h00, 4'h0, 4'h8, 2'b10);
        exec({7'h35, 1'b0, 8'h60});
        verify(1'b1, 12'h060, 1'b1, 8'h00, 1'b0, 8'h00, 4'h0, 4'h8, 2'b10);
        exec({7'h35, 1'b1, 8'h20});
        verify(1'b1, 12'h320, 1'b1, 8'h00, 1'b0, 8'h00, 4'h0, 4'h8, 2'b10);
        ext_set_en = 1'b0;
    endtask

    // reset in the middle of a clear
    task automatic t_reset;
        ccw_mem_model_i.mem[12'h021] = 8'h77;
        wait_phase(2'd0);
        instr_valid = 1'b1;
        instr_word = {7'h35, 1'b0, 8'h21};
        @(negedge sys_clk);
        instr_valid = 1'b0;
        rstn = 1'b0;
        @(negedge sys_clk);
        rstn = 1'b1;
        chk("reset_mid", 12'h000, 12'({phase, mem_req.rd, mem_req.we, w_we, wdt_clr}));
        repeat (4) begin
            @(negedge sys_clk);
            chk("after_reset", 12'h000, 12'({mem_req.we, w_we, wdt_clr, flag_upd.z_we}));
        end
        chk("mem_021", 12'h077, 12'(ccw_mem_model_i.mem[12'h021]));
    endtask

    // word outside Q1 and unknown word
    task automatic t_refused;
        wait_phase(2'd1);
        instr_valid = 1'b1;
        instr_word = {7'h35, 1'b0, 8'h20};
        for (int i = 0; i < 4; i++) begin
            @(negedge sys_clk);
            instr_valid = 1'b0;
            chk("refused", 12'h000, 12'({mem_req.rd, mem_req.we}));
        end
        exec(16'h0005);
        verify(1'b0, 12'h000, 1'b0, 8'h00, 1'b0, 8'h00, 4'h0, 4'h0, 2'b00);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial begin
        rstn = 1'b0;
        instr_valid = 1'b0;
        instr_word = 16'h0000;
        ext_set_en = 1'b0;
        bank_pointer_register = 4'h0;
        index_base = 12'h000;
        err_count = 0;
        total_checks = 0;
        repeat (4) @(negedge sys_clk);
        chk("reset_phase", 12'h000, 12'({phase, mem_req.rd, mem_req.we, w_we, wdt_clr}));
        rstn = 1'b1;
        t_clear();
        t_inv_mem();
        t_inv_w();
        t_wdt();
        t_indexed();
        t_reset();
        t_refused();
        print_verdict();
    end
endmodule

`default_nettype wire
